// file: hw/rsj_pkg.sv
// Purpose: Shared constants and types for the rotate/subtract/jump executor
// Assumes: 8-bit data path, 16-bit program counter
// Notes:   Opcodes, reset values and bit-address layout live here only once
package rsj_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Opcode encodings
    localparam logic [7:0] OP_IRET      = 8'h32;
    localparam logic [7:0] OP_ROT_L     = 8'h23;
    localparam logic [7:0] OP_ROT_LC    = 8'h33;
    localparam logic [7:0] OP_ROT_R     = 8'h03;
    localparam logic [7:0] OP_ROT_RC    = 8'h13;
    localparam logic [7:0] OP_SET_CY    = 8'hd3;
    localparam logic [7:0] OP_SET_BIT   = 8'hd2;
    localparam logic [7:0] OP_SHORT_JMP = 8'h80;
    localparam logic [7:0] OP_SUB_IMM   = 8'h94;
    localparam logic [7:0] OP_SUB_DIR   = 8'h95;
    localparam logic [7:0] OP_NIB_SWAP  = 8'hc4;
    // Masked groups: upper five bits for register forms, upper seven for indirect
    localparam logic [4:0] GRP_SUB_REG  = 5'h13;
    localparam logic [6:0] GRP_SUB_IND  = 7'h4b;
    localparam logic [4:0] GRP_EXCH_REG = 5'h19;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and address layout
    localparam logic [15:0] PC_RESET    = 16'h0000;
    localparam logic [7:0]  STACK_RESET = 8'h07;
    localparam logic [7:0]  ACC_RESET   = 8'h00;
    localparam logic [7:0]  BIT_RAM_BASE = 8'h20; // First of the bytes holding bit addresses 00..7f
    localparam int          BIT_SFR_POS = 7;      // Bit addresses at or above 80 map to SFRs

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer states, one-hot
    typedef enum logic [6:0] {
        S_FETCH = 7'b0000001,
        S_OPC   = 7'b0000010,
        S_OPND  = 7'b0000100,
        S_RAM   = 7'b0001000,
        S_BIT   = 7'b0010000,
        S_POPH  = 7'b0100000,
        S_POPL  = 7'b1000000
    } seq_state_t;

endpackage

// file: hw/subtract_with_borrow_op_alu.sv
// Purpose: Eight-bit subtract with borrow and its three flags
// Assumes: Purely combinational, used inside the executor
// Notes:   Borrow chain is formed from a 9-bit difference plus nibble and 7-bit slices
`timescale 1ns/1ps
`default_nettype none
module subtract_with_borrow_op_alu (
    input  wire logic [7:0] minuend,
    input  wire logic [7:0] subtrahend,
    input  wire logic       borrowIn,
    output logic      [7:0] diff,
    output logic            borrowOut,
    output logic            halfBorrow,
    output logic            overflow
);
    logic [8:0] full;
    logic [4:0] low4;
    logic [7:0] low7;

    // Separate slices expose the borrows out of bit 3 and out of bit 6
    always_comb begin
        full       = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrowIn};
        low4       = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, borrowIn};
        low7       = {1'b0, minuend[6:0]} - {1'b0, subtrahend[6:0]} - {7'h00, borrowIn};
        diff       = full[7:0];
        borrowOut  = full[8];
        halfBorrow = low4[4];
        overflow   = low7[7] ^ full[8];
    end
endmodule
`default_nettype wire

// file: hw/rotate_subtract_jump_exec.sv
// Purpose: Decode and execute return, rotate, bit set, short jump, subtract and exchange
// Assumes: Code and data memories answer combinationally at the registered address
// Notes:   One instruction at a time; unknown opcodes are skipped as one-byte no-ops
//
// Notes on behaviour
// - Interrupt return pops PC high then low
// - One instruction runs before a pending interrupt
// - Interrupt return releases the serviced priority level
// - Interrupt return leaves flags and accumulator alone
// - Rotate left, bit 7 wraps to bit 0
// - Rotate left through carry
// - Rotate right, bit 0 wraps to bit 7
// - Rotate right through carry
// - Bit set on carry or addressable bit
// - Short jump adds signed displacement after two
// - Subtract accumulator, carry and operand; carry is borrow
// - Auxiliary carry is borrow out of bit 3
// - Overflow is borrow out of bit 6 xor out of bit 7
// - Subtract decodes register, direct, indirect, immediate
// - Nibble swap exchanges accumulator halves
// - Exchange swaps accumulator and register
`timescale 1ns/1ps
`default_nettype none
module rotate_subtract_jump_exec
    import rsj_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic [7:0]  codeData,
    input  wire logic [7:0]  ramRdData,
    input  wire logic [1:0]  regBank,
    output logic      [15:0] codeAddr,
    output logic      [7:0]  ramAddr,
    output logic      [7:0]  ramWrData,
    output logic             ramWe,
    output logic      [15:0] pc,
    output logic      [7:0]  stackPointer,
    output logic      [7:0]  acc,
    output logic             cy,
    output logic             auxiliaryCarryFlag,
    output logic             overflowFlag,
    output logic             levelRelease,
    output logic             holdOff,
    output logic             instrDone,
    output logic             unknownOp
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers
    function automatic logic [7:0] bitByte(input logic [7:0] bitAddr);
        if (bitAddr[BIT_SFR_POS]) begin
            bitByte = {bitAddr[7:3], 3'b000};
        end else begin
            bitByte = BIT_RAM_BASE + {4'h0, bitAddr[6:3]};
        end
    endfunction

    function automatic logic [7:0] regAddr(input logic [1:0] bank, input logic [2:0] r);
        regAddr = {3'b000, bank, r};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State and next values
    seq_state_t  state, next_state;
    logic [7:0]  opcode, next_opcode;
    logic [7:0]  operand, next_operand;
    logic        indPending, next_indPending;
    logic [15:0] next_codeAddr, next_pc;
    logic [7:0]  next_ramAddr, next_ramWrData, next_stackPointer, next_acc;
    logic        next_ramWe, next_cy, next_auxiliaryCarryFlag, next_overflowFlag;
    logic        next_levelRelease, next_holdOff, next_instrDone, next_unknownOp;

    logic [7:0]  subSrc, subDiff;
    logic        subBorrow, subHalf, subOvf;

    subtract_with_borrow_op_alu u_alu (
        .minuend    (acc),
        .subtrahend (subSrc),
        .borrowIn   (cy),
        .diff       (subDiff),
        .borrowOut  (subBorrow),
        .halfBorrow (subHalf),
        .overflow   (subOvf)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer: fetch, decode, operand and memory steps in one place
    always_comb begin
        next_state        = state;
        next_opcode       = opcode;
        next_operand      = operand;
        next_indPending   = indPending;
        next_codeAddr     = codeAddr;
        next_pc           = pc;
        next_ramAddr      = ramAddr;
        next_ramWrData    = ramWrData;
        next_ramWe        = 1'b0;
        next_stackPointer       = stackPointer;
        next_acc                = acc;
        next_cy                 = cy;
        next_auxiliaryCarryFlag = auxiliaryCarryFlag;
        next_overflowFlag       = overflowFlag;
        next_levelRelease = 1'b0;
        next_holdOff      = holdOff;
        next_instrDone    = 1'b0;
        next_unknownOp    = 1'b0;
        // Operand source: immediate byte in the operand step, memory byte otherwise
        subSrc            = (state == S_OPND) ? codeData : ramRdData;
        case (state)
            S_FETCH: begin
                next_codeAddr = pc;
                next_pc       = pc + 16'h0001;
                next_state    = S_OPC;
            end
            S_OPC: begin
                next_opcode    = codeData;
                next_state     = S_FETCH;
                next_instrDone = 1'b1;
                if (codeData == OP_IRET) begin
                    next_ramAddr      = stackPointer;
                    next_stackPointer = stackPointer - 8'h01;
                    next_state     = S_POPH;
                    next_instrDone = 1'b0;
                end else if (codeData == OP_ROT_L) begin
                    next_acc = {acc[6:0], acc[7]};
                end else if (codeData == OP_ROT_LC) begin
                    next_acc = {acc[6:0], cy};
                    next_cy  = acc[7];
                end else if (codeData == OP_ROT_R) begin
                    next_acc = {acc[0], acc[7:1]};
                end else if (codeData == OP_ROT_RC) begin
                    next_acc = {cy, acc[7:1]};
                    next_cy  = acc[0];
                end else if (codeData == OP_SET_CY) begin
                    next_cy = 1'b1;
                end else if (codeData == OP_NIB_SWAP) begin
                    next_acc = {acc[3:0], acc[7:4]};
                end else if (codeData == OP_SET_BIT || codeData == OP_SHORT_JMP
                             || codeData == OP_SUB_IMM || codeData == OP_SUB_DIR) begin
                    // Second byte follows the opcode
                    next_codeAddr  = pc;
                    next_pc        = pc + 16'h0001;
                    next_state     = S_OPND;
                    next_instrDone = 1'b0;
                end else if (codeData[7:3] == GRP_SUB_REG
                             || codeData[7:3] == GRP_EXCH_REG) begin
                    next_ramAddr    = regAddr(regBank, codeData[2:0]);
                    next_indPending = 1'b0;
                    next_state      = S_RAM;
                    next_instrDone  = 1'b0;
                end else if (codeData[7:1] == GRP_SUB_IND) begin
                    // Pointer register first, then the byte it points at
                    next_ramAddr    = regAddr(regBank, {2'b00, codeData[0]});
                    next_indPending = 1'b1;
                    next_state      = S_RAM;
                    next_instrDone  = 1'b0;
                end else begin
                    next_unknownOp = 1'b1;
                end
            end
            S_OPND: begin
                next_operand   = codeData;
                next_state     = S_FETCH;
                next_instrDone = 1'b1;
                if (opcode == OP_SHORT_JMP) begin
                    // PC already sits two past the opcode here
                    next_pc = pc + {{8{codeData[7]}}, codeData};
                end else if (opcode == OP_SUB_IMM) begin
                    next_acc = subDiff;
                    next_cy  = subBorrow;
                    next_auxiliaryCarryFlag = subHalf;
                    next_overflowFlag       = subOvf;
                end else if (opcode == OP_SUB_DIR) begin
                    next_ramAddr    = codeData;
                    next_indPending = 1'b0;
                    next_state      = S_RAM;
                    next_instrDone  = 1'b0;
                end else begin
                    next_ramAddr   = bitByte(codeData);
                    next_state     = S_BIT;
                    next_instrDone = 1'b0;
                end
            end
            S_RAM: begin
                if (indPending) begin
                    next_ramAddr    = ramRdData;
                    next_indPending = 1'b0;
                end else begin
                    next_state     = S_FETCH;
                    next_instrDone = 1'b1;
                    if (opcode[7:3] == GRP_EXCH_REG) begin
                        next_acc       = ramRdData;
                        next_ramWrData = acc;
                        next_ramWe     = 1'b1;
                    end else begin
                        next_acc = subDiff;
                        next_cy  = subBorrow;
                        next_auxiliaryCarryFlag = subHalf;
                        next_overflowFlag       = subOvf;
                    end
                end
            end
            S_BIT: begin
                // Read-modify-write keeps the other seven bits of the byte
                next_ramWrData = ramRdData | (8'h01 << operand[2:0]);
                next_ramWe     = 1'b1;
                next_state     = S_FETCH;
                next_instrDone = 1'b1;
            end
            S_POPH: begin
                next_pc[15:8] = ramRdData;
                next_ramAddr      = stackPointer;
                next_stackPointer = stackPointer - 8'h01;
                next_state    = S_POPL;
            end
            S_POPL: begin
                // Flags and accumulator are not restored here
                next_pc[7:0]      = ramRdData;
                next_levelRelease = 1'b1;
                next_state        = S_FETCH;
                next_instrDone    = 1'b1;
            end
            default: begin
                next_state = S_FETCH;
            end
        endcase
        // Hold-off spans the return's completion through the next instruction
        if (state == S_POPL) begin
            next_holdOff = 1'b1;
        end else if (holdOff && next_instrDone) begin
            next_holdOff = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state        <= S_FETCH;
            opcode       <= 8'h00;
            operand      <= 8'h00;
            indPending   <= 1'b0;
            codeAddr     <= PC_RESET;
            pc           <= PC_RESET;
            ramAddr      <= 8'h00;
            ramWrData    <= 8'h00;
            ramWe        <= 1'b0;
            stackPointer       <= STACK_RESET;
            acc                <= ACC_RESET;
            cy                 <= 1'b0;
            auxiliaryCarryFlag <= 1'b0;
            overflowFlag       <= 1'b0;
            levelRelease <= 1'b0;
            holdOff      <= 1'b0;
            instrDone    <= 1'b0;
            unknownOp    <= 1'b0;
        end else begin
            state        <= next_state;
            opcode       <= next_opcode;
            operand      <= next_operand;
            indPending   <= next_indPending;
            codeAddr     <= next_codeAddr;
            pc           <= next_pc;
            ramAddr      <= next_ramAddr;
            ramWrData    <= next_ramWrData;
            ramWe        <= next_ramWe;
            stackPointer       <= next_stackPointer;
            acc                <= next_acc;
            cy                 <= next_cy;
            auxiliaryCarryFlag <= next_auxiliaryCarryFlag;
            overflowFlag       <= next_overflowFlag;
            levelRelease <= next_levelRelease;
            holdOff      <= next_holdOff;
            instrDone    <= next_instrDone;
            unknownOp    <= next_unknownOp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_iret_sp_drop: assert property (@(posedge clk_sys) disable iff (!rstn)
        (state == S_OPC && codeData == OP_IRET)
            |-> ##3 (stackPointer == $past(stackPointer, 3) - 8'h02))
        else $error("Return did not drop stack pointer by two");
    chk_iret_release: assert property (@(posedge clk_sys) disable iff (!rstn)
        (state == S_OPC && codeData == OP_IRET) |-> ##3 (levelRelease && holdOff))
        else $error("Return did not release level and start hold-off");
    chk_iret_keeps_acc: assert property (@(posedge clk_sys) disable iff (!rstn)
        (state == S_OPC && codeData == OP_IRET) |-> ##3 (acc == $past(acc, 3) && cy == $past(cy, 3)))
        else $error("Return disturbed accumulator or carry");
    // The first completion that is not itself a return must close the hold-off window
    chk_holdoff_one: assert property (@(posedge clk_sys) disable iff (!rstn)
        (instrDone && !levelRelease) |-> !holdOff)
        else $error("Hold-off did not end after one instruction");
    chk_rot_left: assert property (@(posedge clk_sys) disable iff (!rstn)
        (state == S_OPC && codeData == OP_ROT_L) |=> (acc == {$past(acc[6:0]), $past(acc[7])}
            && cy == $past(cy)))
        else $error("Rotate left result wrong");
    chk_rot_rc: assert property (@(posedge clk_sys) disable iff (!rstn)
        (state == S_OPC && codeData == OP_ROT_RC) |=> (acc == {$past(cy), $past(acc[7:1])}
            && cy == $past(acc[0])))
        else $error("Rotate right through carry wrong");
    chk_short_jump: assert property (@(posedge clk_sys) disable iff (!rstn)
        (state == S_OPND && opcode == OP_SHORT_JMP)
            |=> (pc == $past(pc) + {{8{$past(codeData[7])}}, $past(codeData)}))
        else $error("Short jump target wrong");
    chk_sub_imm: assert property (@(posedge clk_sys) disable iff (!rstn)
        (state == S_OPND && opcode == OP_SUB_IMM)
            |=> (acc == $past(acc) - $past(codeData) - {7'h00, $past(cy)}))
        else $error("Immediate subtract result wrong");
    chk_swap: assert property (@(posedge clk_sys) disable iff (!rstn)
        (state == S_OPC && codeData == OP_NIB_SWAP) |=> (acc == {$past(acc[3:0]), $past(acc[7:4])}))
        else $error("Nibble swap wrong");
    chk_exch_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        (state == S_RAM && !indPending && opcode[7:3] == GRP_EXCH_REG)
            |=> (ramWe && ramWrData == $past(acc) && acc == $past(ramRdData)))
        else $error("Exchange did not swap");

endmodule
`default_nettype wire

// file: tb/prog_data_mem.sv
// Purpose: Program memory and internal data RAM facing the executor
// Assumes: Both answer combinationally at the presented address
// Notes:   Code space folds onto 256 bytes; the bench loads both arrays
`timescale 1ns/1ps
`default_nettype none
module prog_data_mem (
    input  wire logic        clk_sys,
    input  wire logic [15:0] codeAddr,
    input  wire logic [7:0]  ramAddr,
    input  wire logic [7:0]  ramWrData,
    input  wire logic        ramWe,
    output logic      [7:0]  codeData,
    output logic      [7:0]  ramRdData
);
    logic [7:0] code [256];
    logic [7:0] ram [256];
    ////////////////////////////////////////////////////////////////////////////
    // Zero-latency reads; opcode and operand come from successive addresses
    assign codeData  = code[codeAddr[7:0]];
    assign ramRdData = ram[ramAddr];
    // Write lands on the edge that sees the strobe, plain always so the bench may preload
    always @(posedge clk_sys) begin
        if (ramWe === 1'b1) begin
            ram[ramAddr] <= ramWrData;
        end
    end
endmodule
`default_nettype wire

// file: tb/rotate_subtract_jump_exec_tb_top.sv
// Purpose: Random instruction stream checked against an integer model
// Assumes: One instruction is placed in code memory after each completion
// Notes:   RAM writes are checked in one sweep at the end of the run
`timescale 1ns/1ps
`default_nettype none
module rotate_subtract_jump_exec_tb_top;
    import rsj_pkg::*;
    logic             clk_sys;
    logic             rstn;
    logic       [1:0] regBank;
    wire logic  [7:0] codeData, ramRdData;
    logic      [15:0] codeAddr, pc;
    logic       [7:0] ramAddr, ramWrData, stackPointer, acc;
    logic             ramWe, cy, auxiliaryCarryFlag, overflowFlag;
    logic             levelRelease, holdOff, instrDone, unknownOp;
    logic      [31:0] seed;
    int errCount, checked, cycles, pcM, stkM, aM, cM, hcM, vM, kind, unkSeen, hoLow, prevRet;
    int sh [256];
    ////////////////////////////////////////////////////////////////////////////
    rotate_subtract_jump_exec dut (.clk_sys(clk_sys), .rstn(rstn), .codeData(codeData),
        .ramRdData(ramRdData), .regBank(regBank), .codeAddr(codeAddr), .ramAddr(ramAddr),
        .ramWrData(ramWrData), .ramWe(ramWe), .pc(pc), .stackPointer(stackPointer),
        .acc(acc), .cy(cy), .auxiliaryCarryFlag(auxiliaryCarryFlag),
        .overflowFlag(overflowFlag), .levelRelease(levelRelease), .holdOff(holdOff),
        .instrDone(instrDone), .unknownOp(unknownOp));
    prog_data_mem mem (.clk_sys(clk_sys), .codeAddr(codeAddr), .ramAddr(ramAddr),
        .ramWrData(ramWrData), .ramWe(ramWe), .codeData(codeData), .ramRdData(ramRdData));
    ////////////////////////////////////////////////////////////////////////////
    // 100 MHz clock and a cycle ceiling well above 400 short instructions
    initial clk_sys = 1'b0;
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            errCount++;
            conclude();
        end
    end
    function automatic int rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return {16'h0000, seed[15:0]};
    endfunction
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errCount++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", checked, errCount);
        if (errCount == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Subtract with borrow on the model; negative partial differences mean a borrow
    task automatic sub(input int s);
        int d;
        d = aM - cM - s;
        hcM = ((aM & 15) - cM - (s & 15)) < 0;
        vM = (((aM & 127) - cM - (s & 127)) < 0) ^ (d < 0);
        cM = d < 0;
        aM = d & 255;
    endtask
    // Place one random instruction at the model's pc and apply its effect
    task automatic gen();
        int p0, b1, r, bk, t;
        logic [7:0] op;
        p0 = pcM;
        kind = rnd() % 15;
        b1 = rnd() % 256;
        r = rnd() % 8;
        bk = rnd() % 4;
        regBank <= bk[1:0];
        pcM = pcM + 1;
        case (kind)
            0: begin
                op = OP_IRET;
                pcM = sh[stkM] * 256 + sh[(stkM + 255) & 255];
                stkM = (stkM + 254) & 255;
            end
            1: begin op = OP_ROT_L; aM = ((aM << 1) | (aM >> 7)) & 255; end
            2: begin op = OP_ROT_LC; t = aM >> 7; aM = ((aM << 1) | cM) & 255; cM = t; end
            3: begin op = OP_ROT_R; aM = (aM >> 1) | ((aM & 1) << 7); end
            4: begin op = OP_ROT_RC; t = aM & 1; aM = (aM >> 1) | (cM << 7); cM = t; end
            5: begin op = OP_SET_CY; cM = 1; end
            6: begin
                op = OP_SET_BIT;
                pcM++;
                t = (b1 < 128) ? 32 + (b1 >> 3) : (b1 & 248);
                sh[t] = sh[t] | (1 << (b1 & 7));
            end
            7: begin op = OP_SHORT_JMP; pcM = p0 + 2 + ((b1 < 128) ? b1 : b1 - 256); end
            8: begin op = {GRP_SUB_REG, r[2:0]}; sub(sh[bk * 8 + r]); end
            9: begin op = OP_SUB_DIR; pcM++; sub(sh[b1]); end
            10: begin op = {GRP_SUB_IND, r[0]}; sub(sh[sh[bk * 8 + (r & 1)]]); end
            11: begin op = OP_SUB_IMM; pcM++; sub(b1); end
            12: begin op = OP_NIB_SWAP; aM = ((aM & 15) << 4) | (aM >> 4); end
            13: begin
                op = {GRP_EXCH_REG, r[2:0]};
                t = sh[bk * 8 + r];
                sh[bk * 8 + r] = aM;
                aM = t;
            end
            default: op = 8'ha5;
        endcase
        pcM = pcM & 16'hffff;
        mem.code[p0 & 255] = op;
        mem.code[(p0 + 1) & 255] = b1[7:0];
    endtask
    // Wait for completion under a bound, noting any skipped-opcode pulse
    task automatic waitDone();
        int k;
        k = 0;
        unkSeen = 0;
        hoLow = 0;
        do begin
            @(posedge clk_sys);
            unkSeen = unkSeen | (unknownOp === 1'b1);
            // Hold-off must stay up through every cycle before the completion after a return
            if (instrDone !== 1'b1) hoLow = hoLow | (holdOff !== 1'b1);
            k++;
        end while (instrDone !== 1'b1 && k < 50);
        if (k >= 50) begin
            errCount++;
            conclude();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rstn = 1'b0;
        regBank = 2'h0;
        seed = 32'h4d24;
        for (int i = 0; i < 256; i++) begin
            sh[i] = rnd() % 256;
            mem.ram[i] = sh[i][7:0];
        end
        pcM = 0;
        stkM = STACK_RESET;
        {aM, cM, hcM, vM, prevRet} = '0;
        repeat (10) @(posedge clk_sys);
        gen();
        rstn <= 1'b1;
        for (int n = 0; n < 400; n++) begin
            waitDone();
            cmp(pc, 16'(pcM));
            cmp(16'(stackPointer), 16'(stkM));
            cmp(16'(acc), 16'(aM));
            cmp(16'({cy, auxiliaryCarryFlag, overflowFlag}), 16'({cM[0], hcM[0], vM[0]}));
            cmp(16'(levelRelease), 16'(kind == 0));
            // Hold-off falls at the edge that raises the next completion
            cmp(16'(holdOff), 16'(kind == 0));
            cmp(16'(hoLow), 16'(prevRet == 0));
            cmp(16'(unkSeen), 16'(kind == 14));
            prevRet = (kind == 0);
            gen();
        end
        // Let the last placed instruction finish and its RAM write land before the sweep
        waitDone();
        @(negedge clk_sys);
        for (int i = 0; i < 256; i++) cmp(16'(mem.ram[i]), 16'(sh[i]));
        conclude();
    end
endmodule
`default_nettype wire
